// File: inc/tsr_pkg.sv
// Package: field layout and decode constants of the per-thread state words
package tsr_pkg;
    // ----------------------------------------------------------------
    // Register and sub-register decode
    // ----------------------------------------------------------------
    localparam logic [3:0] TSR_REGNUM_STATE = 4'h0;
    localparam logic [3:0] TSR_REGNUM_PRIV = 4'h1;
    localparam logic [4:0] TSR_SUB_STATE_MAX = 5'h0c;
    localparam logic [4:0] TSR_SUB_PRIV_ONLY = 5'h00;
    localparam logic [2:0] TSR_DW_IDENTITY = 3'h0;
    localparam logic [2:0] TSR_DW_FAULT_EXC = 3'h1;
    // ----------------------------------------------------------------
    // Identity word fields
    // ----------------------------------------------------------------
    localparam int TSR_SRC_CODE_LSB = 24;
    localparam int TSR_SRC_CODE_W = 4;
    localparam int TSR_PRIO_CLASS_BIT = 23;
    localparam int TSR_AGE_LSB = 16;
    localparam int TSR_AGE_W = 3;
    localparam int TSR_SLICE_LSB = 14;
    localparam int TSR_SUBSLICE_LSB = 12;
    localparam int TSR_EU_LSB = 8;
    localparam int TSR_SLOT_LSB = 0;
    localparam int TSR_SLOT_W = 3;
    // ----------------------------------------------------------------
    // Fault and exception word fields
    // ----------------------------------------------------------------
    localparam int TSR_SRC_THREAD_LSB = 22;
    localparam int TSR_SRC_THREAD_W = 10;
    localparam int TSR_PF_STATUS_BIT = 20;
    localparam int TSR_PF_CODE_LSB = 16;
    localparam int TSR_PF_CODE_W = 3;
    localparam int TSR_PRIV_LSB = 7;
    localparam int TSR_PRIV_W = 9;
    localparam int TSR_EXC_LSB = 0;
    localparam int TSR_EXC_W = 7;
    localparam int TSR_EXC_USED_W = 5;
    localparam int TSR_EXC_INVALID = 0;
    localparam int TSR_EXC_DIV_ZERO = 1;
    localparam int TSR_EXC_UNDERFLOW = 2;
    localparam int TSR_EXC_OVERFLOW = 3;
    localparam int TSR_EXC_INEXACT = 4;
    // Trap enable position in the first control word
    localparam int TSR_CTRL_TRAP_EN_BIT = 9;
    // ----------------------------------------------------------------
    // Reset values and masks
    // ----------------------------------------------------------------
    localparam logic [31:0] TSR_WORD_RST = 32'h0000_0000;
    localparam logic [31:0] TSR_ID_USED_MASK = 32'h0f87_ff07;
    localparam logic [31:0] TSR_FE_USED_MASK = 32'hffd7_ff9f;
    localparam logic [31:0] TSR_FE_SW_WR_MASK = 32'h0000_ff9f;
endpackage

// File: verilog/tsr_thread_state.sv
// Per-thread state words: identity, aging, page fault and sticky exception flags
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Register 0 sub 0..12 valid, register 1 sub 0 only; other codes reserved.
// - Source unit code loaded at dispatch, attached to every outgoing message.
// - High priority class thread scheduled before low; class fixed for thread life.
// - Priority class bit sent with each message as an arbiter hint.
// - Unique 3-bit aging priority; larger number wins within a class.
// - Aging priority cleared to zero when a thread is dispatched.
// - On dispatch, ages increment only in a cascade that keeps them unique.
// - Restore after preemption initialises age as a new thread, not saved value.
// - Placement reported: slice 15:14, subslice 13:12, unit number 11:8.
// - Slot index written into bits 2:0 at dispatch.
// - Source unit thread number held in bits 31:22 of second word.
// - Page fault status set on fault, cleared when thread restarts.
// - Three-bit page fault code recorded in bits 18:16 of second word.
// - Private state bits 15:7 saved and restored intact across preemption.
// - Sticky exception flags 6:0; cleared only by software write or load.
// - Flag updates suppressed while control trap enable is clear.
// - Flags: invalid, divide by zero, underflow, overflow, inexact; upper reserved.
// - Trap enable is control word bit 9, zero at load.
module tsr_thread_state
#(
    parameter int THREADS = 8,
    parameter logic [1:0] SLICE_NUM = 2'h0,
    parameter logic [1:0] SUBSLICE_NUM = 2'h0,
    parameter logic [3:0] EXEC_UNIT_NUM = 4'h0
)
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic disp_valid,
    input wire logic disp_restore,
    input wire logic [tsr_pkg::TSR_SLOT_W-1:0] disp_slot,
    input wire logic [tsr_pkg::TSR_SRC_CODE_W-1:0] disp_source_unit_code,
    input wire logic disp_prio_class,
    input wire logic [tsr_pkg::TSR_SRC_THREAD_W-1:0] disp_source_unit_thread_number,
    input wire logic [tsr_pkg::TSR_PRIV_W-1:0] disp_hw_private,
    input wire logic term_valid,
    input wire logic [tsr_pkg::TSR_SLOT_W-1:0] term_slot,
    input wire logic [THREADS-1:0] thread_ready,
    output logic sched_valid_q,
    output logic [tsr_pkg::TSR_SLOT_W-1:0] sched_slot_q,
    input wire logic msg_req,
    input wire logic [tsr_pkg::TSR_SLOT_W-1:0] msg_slot,
    output logic msg_valid_q,
    output logic [tsr_pkg::TSR_SRC_CODE_W-1:0] msg_source_unit_code_q,
    output logic msg_prio_hint_q,
    input wire logic pf_valid,
    input wire logic [tsr_pkg::TSR_SLOT_W-1:0] pf_slot,
    input wire logic [tsr_pkg::TSR_PF_CODE_W-1:0] pf_code,
    input wire logic pf_restart,
    input wire logic [tsr_pkg::TSR_SLOT_W-1:0] pf_restart_slot,
    input wire logic exc_valid,
    input wire logic [tsr_pkg::TSR_SLOT_W-1:0] exc_slot,
    input wire logic [tsr_pkg::TSR_EXC_USED_W-1:0] exc_flags,
    input wire logic [31:0] exc_ctrl_word,
    input wire logic reg_rd_en,
    input wire logic reg_wr_en,
    input wire logic [tsr_pkg::TSR_SLOT_W-1:0] reg_slot,
    input wire logic [3:0] reg_num,
    input wire logic [4:0] reg_sub,
    input wire logic [31:0] reg_wdata,
    output logic reg_rd_valid_q,
    output logic [31:0] reg_rdata_q,
    output logic reg_err_q
);
    import tsr_pkg::*;

    // ----------------------------------------------------------------
    // Per-thread storage
    // ----------------------------------------------------------------
    logic [THREADS-1:0] active_q;
    logic [THREADS-1:0] prio_class_q;
    logic [TSR_SRC_CODE_W-1:0] src_code_q [THREADS];
    logic [TSR_AGE_W-1:0] age_q [THREADS];
    logic [TSR_SLOT_W-1:0] slot_q [THREADS];
    logic [TSR_SRC_THREAD_W-1:0] src_thread_q [THREADS];
    logic [THREADS-1:0] pf_status_q;
    logic [TSR_PF_CODE_W-1:0] pf_code_q [THREADS];
    logic [TSR_PRIV_W-1:0] priv_q [THREADS];
    logic [TSR_EXC_USED_W-1:0] exc_q [THREADS];

    // ----------------------------------------------------------------
    // Register decode
    // ----------------------------------------------------------------
    logic acc_state;
    logic acc_priv;
    logic acc_valid;
    logic [2:0] acc_dw;
    logic wr_fe;
    logic trap_en;

    always_comb
    begin
        acc_state = (reg_num == TSR_REGNUM_STATE) && (reg_sub <= TSR_SUB_STATE_MAX);
        acc_priv = (reg_num == TSR_REGNUM_PRIV) && (reg_sub == TSR_SUB_PRIV_ONLY);
        acc_valid = acc_state || acc_priv;
        acc_dw = reg_sub[4:2];
        wr_fe = reg_wr_en && acc_state && (acc_dw == TSR_DW_FAULT_EXC);
        trap_en = exc_ctrl_word[TSR_CTRL_TRAP_EN_BIT];
    end

    // ----------------------------------------------------------------
    // Aging cascade
    // ----------------------------------------------------------------
    // A thread moves up only if every age from zero to its own is held,
    // so the chain shifts by one and ages stay unique.
    logic [(1<<TSR_AGE_W)-1:0] age_held;
    logic [(1<<TSR_AGE_W)-1:0] age_run;

    always_comb
    begin
        age_held = '0;
        for (int t = 0; t < THREADS; t++)
        begin
            if (active_q[t] && (t[TSR_SLOT_W-1:0] != disp_slot))
            begin
                age_held[age_q[t]] = 1'b1;
            end
        end
        age_run[0] = age_held[0];
        for (int v = 1; v < (1 << TSR_AGE_W); v++)
        begin
            age_run[v] = age_run[v-1] && age_held[v];
        end
    end

    // ----------------------------------------------------------------
    // Per-thread update
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < THREADS; g++)
        begin : g_thread
            localparam logic [TSR_SLOT_W-1:0] SLOT = TSR_SLOT_W'(g);
            logic load;
            logic exc_set;
            assign load = disp_valid && (disp_slot == SLOT);
            assign exc_set = exc_valid && (exc_slot == SLOT) && trap_en;

            always_ff @(posedge mclk)
            begin
                if (sys_rst)
                begin
                    active_q[g] <= 1'b0;
                end
                else if (load)
                begin
                    active_q[g] <= 1'b1;
                end
                else if (term_valid && (term_slot == SLOT))
                begin
                    active_q[g] <= 1'b0;
                end
            end

            // Dispatcher-owned fields, constant while the thread lives
            always_ff @(posedge mclk)
            begin
                if (sys_rst)
                begin
                    prio_class_q[g] <= 1'b0;
                    src_code_q[g] <= '0;
                    slot_q[g] <= '0;
                    src_thread_q[g] <= '0;
                end
                else if (load)
                begin
                    prio_class_q[g] <= disp_prio_class;
                    src_code_q[g] <= disp_source_unit_code;
                    slot_q[g] <= disp_slot;
                    src_thread_q[g] <= disp_source_unit_thread_number;
                end
            end

            // Restore is treated as a fresh load for aging purposes
            always_ff @(posedge mclk)
            begin
                if (sys_rst)
                begin
                    age_q[g] <= '0;
                end
                else if (load)
                begin
                    age_q[g] <= '0;
                end
                else if (disp_valid && active_q[g] && age_run[age_q[g]])
                begin
                    age_q[g] <= age_q[g] + 1'b1;
                end
            end

            // Fault set wins over a same-cycle restart
            always_ff @(posedge mclk)
            begin
                if (sys_rst)
                begin
                    pf_status_q[g] <= 1'b0;
                    pf_code_q[g] <= '0;
                end
                else if (load && !disp_restore)
                begin
                    pf_status_q[g] <= 1'b0;
                    pf_code_q[g] <= '0;
                end
                else if (pf_valid && (pf_slot == SLOT))
                begin
                    pf_status_q[g] <= 1'b1;
                    pf_code_q[g] <= pf_code;
                end
                else if (pf_restart && (pf_restart_slot == SLOT))
                begin
                    pf_status_q[g] <= 1'b0;
                end
            end

            always_ff @(posedge mclk)
            begin
                if (sys_rst)
                begin
                    priv_q[g] <= '0;
                end
                else if (load)
                begin
                    priv_q[g] <= disp_restore ? disp_hw_private : '0;
                end
                else if (wr_fe && (reg_slot == SLOT))
                begin
                    priv_q[g] <= reg_wdata[TSR_PRIV_LSB +: TSR_PRIV_W];
                end
            end

            // Hardware set is ORed after the software write so it is never lost
            always_ff @(posedge mclk)
            begin
                if (sys_rst)
                begin
                    exc_q[g] <= '0;
                end
                else if (load)
                begin
                    exc_q[g] <= '0;
                end
                else
                begin
                    exc_q[g] <= ((wr_fe && (reg_slot == SLOT))
                                 ? reg_wdata[TSR_EXC_LSB +: TSR_EXC_USED_W] : exc_q[g])
                                | (exc_set ? exc_flags : '0);
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Word assembly and read port
    // ----------------------------------------------------------------
    logic [31:0] id_word;
    logic [31:0] fe_word;

    always_comb
    begin
        id_word = TSR_WORD_RST;
        id_word[TSR_SRC_CODE_LSB +: TSR_SRC_CODE_W] = src_code_q[reg_slot];
        id_word[TSR_PRIO_CLASS_BIT] = prio_class_q[reg_slot];
        id_word[TSR_AGE_LSB +: TSR_AGE_W] = age_q[reg_slot];
        id_word[TSR_SLICE_LSB +: 2] = SLICE_NUM;
        id_word[TSR_SUBSLICE_LSB +: 2] = SUBSLICE_NUM;
        id_word[TSR_EU_LSB +: 4] = EXEC_UNIT_NUM;
        id_word[TSR_SLOT_LSB +: TSR_SLOT_W] = slot_q[reg_slot];
        fe_word = TSR_WORD_RST;
        fe_word[TSR_SRC_THREAD_LSB +: TSR_SRC_THREAD_W] = src_thread_q[reg_slot];
        fe_word[TSR_PF_STATUS_BIT] = pf_status_q[reg_slot];
        fe_word[TSR_PF_CODE_LSB +: TSR_PF_CODE_W] = pf_code_q[reg_slot];
        fe_word[TSR_PRIV_LSB +: TSR_PRIV_W] = priv_q[reg_slot];
        fe_word[TSR_EXC_LSB +: TSR_EXC_USED_W] = exc_q[reg_slot];
    end

    // Mask dispatch and vector words and the private register read zero here
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            reg_rd_valid_q <= 1'b0;
            reg_rdata_q <= TSR_WORD_RST;
            reg_err_q <= 1'b0;
        end
        else
        begin
            reg_rd_valid_q <= reg_rd_en;
            reg_err_q <= (reg_rd_en || reg_wr_en) && !acc_valid;
            if (reg_rd_en && acc_state && (acc_dw == TSR_DW_IDENTITY))
            begin
                reg_rdata_q <= id_word & TSR_ID_USED_MASK;
            end
            else if (reg_rd_en && acc_state && (acc_dw == TSR_DW_FAULT_EXC))
            begin
                reg_rdata_q <= fe_word & TSR_FE_USED_MASK;
            end
            else
            begin
                reg_rdata_q <= TSR_WORD_RST;
            end
        end
    end

    // ----------------------------------------------------------------
    // Message tagging
    // ----------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            msg_valid_q <= 1'b0;
            msg_source_unit_code_q <= '0;
            msg_prio_hint_q <= 1'b0;
        end
        else
        begin
            msg_valid_q <= msg_req;
            if (msg_req)
            begin
                msg_source_unit_code_q <= src_code_q[msg_slot];
                msg_prio_hint_q <= prio_class_q[msg_slot];
            end
        end
    end

    // ----------------------------------------------------------------
    // Scheduler pick: class first, then age
    // ----------------------------------------------------------------
    logic pick_valid;
    logic [TSR_SLOT_W-1:0] pick_slot;
    logic [TSR_AGE_W:0] pick_rank;

    always_comb
    begin
        pick_valid = 1'b0;
        pick_slot = '0;
        pick_rank = '0;
        for (int t = 0; t < THREADS; t++)
        begin
            if (active_q[t] && thread_ready[t]
                && (!pick_valid || ({prio_class_q[t], age_q[t]} > pick_rank)))
            begin
                pick_valid = 1'b1;
                pick_slot = t[TSR_SLOT_W-1:0];
                pick_rank = {prio_class_q[t], age_q[t]};
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            sched_valid_q <= 1'b0;
            sched_slot_q <= '0;
        end
        else
        begin
            sched_valid_q <= pick_valid;
            sched_slot_q <= pick_slot;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    logic ages_unique;
    always_comb
    begin
        ages_unique = 1'b1;
        for (int a = 0; a < THREADS; a++)
        begin
            for (int b = a + 1; b < THREADS; b++)
            begin
                if (active_q[a] && active_q[b] && (age_q[a] == age_q[b]))
                begin
                    ages_unique = 1'b0;
                end
            end
        end
    end

    age_unique_a: assert property (ages_unique)
        else $error("two live threads share an aging value");
    age_cleared_a: assert property (disp_valid |=> age_q[$past(disp_slot)] == '0)
        else $error("dispatched thread age not zero");
    class_stable_a: assert property (!disp_valid |=> $stable(prio_class_q))
        else $error("priority class changed without dispatch");
    msg_tag_a: assert property (msg_req && !disp_valid |=> msg_valid_q
        && msg_source_unit_code_q == src_code_q[$past(msg_slot)]
        && msg_prio_hint_q == prio_class_q[$past(msg_slot)])
        else $error("message tag does not match thread state");
    fault_set_a: assert property (pf_valid && !disp_valid |=> pf_status_q[$past(pf_slot)]
        && pf_code_q[$past(pf_slot)] == $past(pf_code))
        else $error("page fault not recorded");
    trap_gate_a: assert property (!trap_en && !reg_wr_en && !disp_valid |=> $stable(exc_q[0]))
        else $error("flags moved while trap disabled");
    decode_err_a: assert property (reg_rd_en && reg_num == TSR_REGNUM_PRIV
        && reg_sub != TSR_SUB_PRIV_ONLY |=> reg_err_q && reg_rdata_q == '0)
        else $error("reserved sub-register not flagged");
    rsvd_zero_a: assert property (reg_rd_valid_q |-> (reg_rdata_q & ~(TSR_ID_USED_MASK
        | TSR_FE_USED_MASK)) == '0)
        else $error("reserved bits read non-zero");
    place_rd_a: assert property (reg_rd_en && reg_num == TSR_REGNUM_STATE && reg_sub == 5'h00
        |=> reg_rdata_q[15:8] == {SLICE_NUM, SUBSLICE_NUM, EXEC_UNIT_NUM})
        else $error("placement field wrong");

    cascade_c: cover property (disp_valid && active_q[0] && age_run[age_q[0]]);
    fault_c: cover property (pf_valid ##[1:20] pf_restart);
    exc_set_c: cover property (exc_valid && trap_en && exc_flags != '0);
    sched_c: cover property (sched_valid_q && prio_class_q[sched_slot_q]);
endmodule
`default_nettype wire

// File: verification/tsr_disp_model.sv
// Dispatcher model: registers bench requests onto the dispatch lines one cycle later
`timescale 1ns/1ps
`default_nettype none
module tsr_disp_model
(
    input wire logic mclk,
    input wire logic go,
    input wire logic rq_restore,
    input wire logic rq_cls,
    input wire logic [2:0] rq_slot,
    input wire logic [3:0] rq_code,
    input wire logic [9:0] rq_tn,
    input wire logic [8:0] rq_priv,
    output logic disp_valid,
    output logic disp_restore,
    output logic disp_prio_class,
    output logic [2:0] disp_slot,
    output logic [3:0] disp_source_unit_code,
    output logic [9:0] disp_source_unit_thread_number,
    output logic [8:0] disp_hw_private
);
    initial
    begin
        {disp_valid, disp_restore, disp_prio_class, disp_slot} = 6'h00;
        {disp_source_unit_code, disp_source_unit_thread_number, disp_hw_private} = 23'h0;
    end
    // Idle data lines toggle so a stale value never passes for a fresh one
    always @(posedge mclk)
    begin
        disp_valid <= go;
        disp_restore <= go & rq_restore;
        if (go)
        begin
            disp_slot <= rq_slot;
            disp_source_unit_code <= rq_code;
            disp_prio_class <= rq_cls;
            disp_source_unit_thread_number <= rq_tn;
            disp_hw_private <= rq_priv;
        end
        else
        begin
            {disp_slot, disp_source_unit_code, disp_prio_class} <=
                ~{disp_slot, disp_source_unit_code, disp_prio_class};
            {disp_source_unit_thread_number, disp_hw_private} <=
                ~{disp_source_unit_thread_number, disp_hw_private};
        end
    end
endmodule
`default_nettype wire

// File: verification/test_thread_state_register.sv
// Bench: dispatch, message, fault, exception and decode checks of the state words
`timescale 1ns/1ps
`default_nettype none
module test_thread_state_register;
    import tsr_pkg::*;
    logic mclk, sys_rst, go, rq_restore, rq_cls, disp_valid, disp_restore, disp_prio_class;
    logic term_valid, msg_req, pf_valid, pf_restart, exc_valid, reg_rd_en, reg_wr_en;
    logic sched_valid_q, msg_valid_q, msg_prio_hint_q, reg_rd_valid_q, reg_err_q;
    logic [2:0] rq_slot, disp_slot, term_slot, sched_slot_q, msg_slot, pf_slot, pf_code;
    logic [2:0] pf_restart_slot, exc_slot, reg_slot;
    logic [3:0] rq_code, disp_source_unit_code, msg_source_unit_code_q, reg_num;
    logic [4:0] exc_flags, reg_sub;
    logic [7:0] thread_ready;
    logic [8:0] rq_priv, disp_hw_private;
    logic [9:0] rq_tn, disp_source_unit_thread_number;
    logic [31:0] exc_ctrl_word, reg_wdata, reg_rdata_q, lf;
    logic [32:0] rq[$], mq[$];
    logic [3:0] e_code[8] = '{default: 4'h0};
    logic [2:0] e_age[8] = '{default: 3'h0};
    logic [2:0] e_pfc[8] = '{default: 3'h0};
    logic e_cls[8] = '{default: 1'b0};
    logic e_live[8] = '{default: 1'b0};
    logic e_pfs[8] = '{default: 1'b0};
    logic [9:0] e_tn[8] = '{default: 10'h0};
    logic [8:0] e_priv[8] = '{default: 9'h0};
    logic [4:0] e_flg[8] = '{default: 5'h0};
    logic [9:0] tbl[8] = '{10'h010, 10'h018, 10'h01b, 10'h021, 10'h040, 10'h043, 10'h081, 10'h3c1};
    int failures = 0;
    int checked = 0;

    tsr_disp_model tsr_disp_model_i (.mclk, .go, .rq_restore, .rq_cls, .rq_slot, .rq_code,
        .rq_tn, .rq_priv, .disp_valid, .disp_restore, .disp_prio_class, .disp_slot,
        .disp_source_unit_code, .disp_source_unit_thread_number, .disp_hw_private);
    tsr_thread_state #(.SLICE_NUM(2'h2), .SUBSLICE_NUM(2'h1), .EXEC_UNIT_NUM(4'h5))
        tsr_thread_state_i (.mclk, .sys_rst, .disp_valid, .disp_restore, .disp_slot,
        .disp_source_unit_code, .disp_prio_class, .disp_source_unit_thread_number,
        .disp_hw_private, .term_valid, .term_slot, .thread_ready, .sched_valid_q,
        .sched_slot_q, .msg_req, .msg_slot, .msg_valid_q, .msg_source_unit_code_q,
        .msg_prio_hint_q, .pf_valid, .pf_slot, .pf_code, .pf_restart, .pf_restart_slot,
        .exc_valid, .exc_slot, .exc_flags, .exc_ctrl_word, .reg_rd_en, .reg_wr_en, .reg_slot,
        .reg_num, .reg_sub, .reg_wdata, .reg_rd_valid_q, .reg_rdata_q, .reg_err_q);

    initial mclk = 1'b0;
    always #12.5 mclk = ~mclk;

    function automatic logic [31:0] id_word(input logic [2:0] s);
        return {4'h0, e_code[s], e_cls[s], 4'h0, e_age[s], 2'h2, 2'h1, 4'h5, 5'h00, s};
    endfunction
    function automatic logic [31:0] fe_word(input logic [2:0] s);
        return {e_tn[s], 1'b0, e_pfs[s], 1'b0, e_pfc[s], e_priv[s], 2'h0, e_flg[s]};
    endfunction
    function automatic void step();
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    endfunction
    task automatic cyc();
        @(posedge mclk);
        #2;
    endtask
    task automatic chk(input string name, input logic [32:0] exp, input logic [32:0] got);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        failures += rq.size() + mq.size();
        $display("counts: checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic rd(input logic [2:0] s, input logic [3:0] n, input logic [4:0] sb,
                      input logic [32:0] e);
        reg_rd_en = 1'b1;
        reg_slot = s;
        reg_num = n;
        reg_sub = sb;
        rq.push_back(e);
        cyc();
        reg_rd_en = 1'b0;
        cyc();
    endtask
    task automatic wr(input logic [2:0] s, input logic [4:0] sb, input logic [31:0] w);
        reg_wr_en = 1'b1;
        reg_slot = s;
        reg_num = 4'h0;
        reg_sub = sb;
        reg_wdata = w;
        if (sb == 5'h04)
            {e_priv[s], e_flg[s]} = {w[15:7], w[4:0]};
        cyc();
        reg_wr_en = 1'b0;
        cyc();
        rd(s, 4'h0, sb, {1'b0, sb == 5'h04 ? fe_word(s) : id_word(s)});
    endtask
    task automatic disp(input logic [2:0] s, input logic r, input logic c);
        logic [2:0] oa[8];
        logic hit;
        step();
        {go, rq_slot, rq_restore, rq_cls, rq_code, rq_tn} = {1'b1, s, r, c, lf[13:0]};
        rq_priv = r ? lf[22:14] : 9'h000;
        oa = e_age;
        for (int v = 0; v < 7; v++)
        begin
            hit = 1'b0;
            for (int k = 0; k < 8; k++)
                if (e_live[k] && k != s && oa[k] == v)
                begin
                    e_age[k] = 3'(v + 1);
                    hit = 1'b1;
                end
            if (!hit)
                break;
        end
        {e_age[s], e_live[s], e_code[s], e_cls[s], e_tn[s]} = {4'h1, rq_code, c, rq_tn};
        {e_priv[s], e_flg[s]} = {rq_priv, 5'h00};
        if (!r)
            {e_pfs[s], e_pfc[s]} = 4'h0;
        cyc();
    endtask
    task automatic event_pulse(input int kind, input logic [2:0] s, input logic [31:0] c);
        step();
        case (kind)
            0: {pf_valid, pf_slot, pf_code, e_pfs[s], e_pfc[s]} =
                {1'b1, s, lf[2:0], 1'b1, lf[2:0]};
            1: {pf_restart, pf_restart_slot, e_pfs[s]} = {1'b1, s, 1'b0};
            default: {exc_valid, exc_slot, exc_flags, exc_ctrl_word} = {1'b1, s, lf[4:0], c};
        endcase
        if (kind == 2 && c[9])
            e_flg[s] = e_flg[s] | lf[4:0];
        cyc();
        {pf_valid, pf_restart, exc_valid} = 3'h0;
        cyc();
        rd(s, 4'h0, 5'h04, {1'b0, fe_word(s)});
    endtask

    always @(posedge mclk)
    begin
        if ((reg_rd_valid_q | reg_err_q) === 1'b1 && rq.size() > 0)
            chk("reg_read", rq.pop_front(), {reg_err_q, reg_rdata_q});
        if (msg_valid_q === 1'b1 && mq.size() > 0)
            chk("msg_tag", mq.pop_front(),
                {28'h0, msg_source_unit_code_q, msg_prio_hint_q});
    end

    initial
    begin
        repeat (5000) @(posedge mclk);
        failures++;
        tally_and_finish();
    end

    initial
    begin
        {sys_rst, go, rq_restore, rq_cls, term_valid, msg_req, pf_valid, pf_restart} = 8'h80;
        {exc_valid, reg_rd_en, reg_wr_en, rq_slot, term_slot, msg_slot} = 12'h0;
        {pf_slot, pf_code, pf_restart_slot, exc_slot, reg_slot, reg_num, reg_sub} = 24'h0;
        {rq_code, rq_tn, rq_priv, exc_flags, thread_ready, exc_ctrl_word, reg_wdata} = 100'h0;
        lf = 32'hf31ede33;
        repeat (4) @(posedge mclk);
        #2;
        sys_rst = 1'b0;
        rd(3'h0, 4'h0, 5'h00, {1'b0, id_word(3'h0)});
        rd(3'h0, 4'h0, 5'h04, 33'h0);
        $display("test reset done");
        disp(3'h0, 1'b0, 1'b0);
        disp(3'h1, 1'b0, 1'b0);
        disp(3'h2, 1'b0, 1'b1);
        go = 1'b0;
        cyc();
        for (int s = 0; s < 3; s++)
            rd(3'(s), 4'h0, 5'h00, {1'b0, id_word(3'(s))});
        $display("test dispatch done");
        for (int k = 0; k < 2; k++)
        begin
            thread_ready = k == 0 ? 8'h07 : 8'h03;
            repeat (3) cyc();
            chk("sched", k == 0 ? 33'h00a : 33'h008,
                {29'h0, sched_valid_q, sched_slot_q});
        end
        for (int s = 0; s < 3; s++)
        begin
            {msg_req, msg_slot} = {1'b1, 3'(s)};
            mq.push_back({28'h0, e_code[s], e_cls[s]});
            cyc();
            msg_req = 1'b0;
            cyc();
        end
        $display("test schedule and message done");
        event_pulse(0, 3'h1, 32'h0);
        event_pulse(2, 3'h0, 32'hffff_fdff);
        for (int k = 0; k < 3; k++)
            event_pulse(2, 3'h0, 32'h0000_0200);
        step();
        wr(3'h0, 5'h04, lf | 32'h0000_0060);
        wr(3'h0, 5'h00, ~lf);
        $display("test fault and exception done");
        {term_valid, term_slot, e_live[1]} = {1'b1, 3'h1, 1'b0};
        cyc();
        term_valid = 1'b0;
        disp(3'h1, 1'b1, 1'b0);
        go = 1'b0;
        cyc();
        rd(3'h1, 4'h0, 5'h00, {1'b0, id_word(3'h1)});
        rd(3'h1, 4'h0, 5'h04, {1'b0, fe_word(3'h1)});
        event_pulse(1, 3'h1, 32'h0);
        $display("test restore done");
        for (int k = 0; k < 8; k++)
            rd(3'h2, tbl[k][9:6], tbl[k][5:1], {tbl[k][0], 32'h0});
        $display("test decode done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
